// >>> tcc_defs.vh
/*
 * Register offsets, field positions, reset values and mode codes of the
 * dual 16-bit compare and capture block.
 * Assumes a byte-addressed APB slave with one aligned 32-bit word per
 * register and the narrow data in the low bits.
 */
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Control and status words.
`define TCC_OFS_T1_MASK   8'h00
`define TCC_OFS_T3_MASK   8'h04
`define TCC_OFS_T1_FLAGS  8'h08
`define TCC_OFS_T3_FLAGS  8'h0c
`define TCC_OFS_T1_CTRL   8'h10
`define TCC_OFS_T3_CTRL   8'h14
`define TCC_OFS_T1_FORCE  8'h18
`define TCC_OFS_T3_FORCE  8'h1c

// Byte windows of the 16-bit values; bit 6 of the address picks the timer.
`define TCC_OFS_WIDE_BASE 8'h20
`define TCC_OFS_WIDE_LAST 8'h5c
`define TCC_WIDE_T3_BIT   6
`define TCC_IDX_CMPA_LO   3'h0
`define TCC_IDX_CMPA_HI   3'h1
`define TCC_IDX_CMPB_LO   3'h2
`define TCC_IDX_CMPB_HI   3'h3
`define TCC_IDX_CMPC_LO   3'h4
`define TCC_IDX_CMPC_HI   3'h5
`define TCC_IDX_CAP_LO    3'h6
`define TCC_IDX_CAP_HI    3'h7

// Mask and flag layout.
`define TCC_BIT_OVF       0
`define TCC_BIT_CMPA      1
`define TCC_BIT_CMPB      2
`define TCC_BIT_CMPC      3
`define TCC_BIT_CAP       5
`define TCC_FLAG_USED     8'h2f
`define TCC_MASK_RESET    8'h00
`define TCC_FLAGS_RESET   8'h00

// Control word layout.
`define TCC_CTRL_MODE_LSB 0
`define TCC_CTRL_MODE_MSB 3
`define TCC_CTRL_RISING   4
`define TCC_CTRL_USE_COMP 5
`define TCC_CTRL_USED     8'h3f
`define TCC_CTRL_RESET    8'h00

// Waveform mode codes with a special meaning here.
`define TCC_MODE_NORMAL   4'h0
`define TCC_MODE_CTC_CMPA 4'h4
`define TCC_MODE_CTC_CAP  4'hc
`define TCC_MODE_RESVD    4'hd
`define TCC_MODE_FPWM_CAP 4'he

`endif

// >>> tcc_edge.v
/*
 * Capture event detector for one timer: picks the pin or the comparator,
 * detects the selected edge and emits a one-cycle event.
 * Assumes inputs synchronous to clk_sys_in and a synchronous low reset.
 */
module tcc_edge
(
	input  wire clk_sys_in,
	input  wire rst_n_in,
	input  wire pin_in,
	input  wire comp_in,
	input  wire use_comp_in,
	input  wire rising_in,
	input  wire enable_in,
	output wire evt_out
);
	reg  prev_ff;
	reg  evt_ff;
	wire src;
	wire nxt_evt;

	// The chosen source and the edge wanted on it.
	assign src = use_comp_in ? comp_in : pin_in;
	assign nxt_evt = enable_in &&
		(rising_in ? (src && !prev_ff) : (!src && prev_ff));

	// Previous sample and registered event.
	always @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			prev_ff <= 1'b0;
			evt_ff  <= 1'b0;
		end
		else
		begin
			prev_ff <= src;
			evt_ff  <= nxt_evt;
		end
	end

	assign evt_out = evt_ff;
endmodule

// >>> tcc_chan.v
/*
 * One timer: three compare values with match detection, the capture value
 * and the sticky flag register.
 * Assumes the counter unit outside gives the count, a tick per timer clock
 * and one-cycle max, top and bottom events.
 */
`include "tcc_defs.vh"
module tcc_chan #(parameter WIDTH = 16)
(
	input  wire             clk_sys_in,
	input  wire             rst_n_in,
	input  wire [2:0]       cmp_wr_in,
	input  wire             cap_wr_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire [7:0]       flag_clr_in,
	input  wire [7:0]       vec_ack_in,
	input  wire [3:0]       mode_in,
	input  wire [WIDTH-1:0] counter_in,
	input  wire             tick_in,
	input  wire             max_in,
	input  wire             top_in,
	input  wire             bottom_in,
	input  wire             cap_evt_in,
	output wire [WIDTH*3-1:0] cmp_out,
	output wire [WIDTH-1:0] cap_out,
	output wire [2:0]       match_out,
	output wire [7:0]       flags_out,
	output wire             cap_is_top_out
);
	reg  [WIDTH-1:0] cmp_ff [0:2];
	reg  [2:0]       match_ff;
	reg  [WIDTH-1:0] cap_ff;
	reg  [7:0]       flags_ff;
	reg  [7:0]       set_vec;
	reg              ovf_evt;
	wire             cap_is_top;
	genvar           gi;

	assign cap_is_top = (mode_in == `TCC_MODE_CTC_CAP) ||
		(mode_in == `TCC_MODE_FPWM_CAP);

	// Per channel: storage, and a match caught on the timer tick.
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_cmp
			always @(posedge clk_sys_in)
			begin
				if (!rst_n_in)
				begin
					cmp_ff[gi]   <= {WIDTH{1'b0}};
					match_ff[gi] <= 1'b0;
				end
				else
				begin
					if (cmp_wr_in[gi])
						cmp_ff[gi] <= wr_data_in;
					match_ff[gi] <= tick_in &&
						(counter_in == cmp_ff[gi]);
				end
			end
			assign cmp_out[gi*WIDTH +: WIDTH] = cmp_ff[gi];
		end
	endgenerate

	// Overflow event source depends on the waveform mode.
	always @*
	begin
		ovf_evt = 1'b0;
		case (mode_in)
			4'h0, 4'h4, 4'hc: ovf_evt = max_in;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: ovf_evt = bottom_in;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: ovf_evt = top_in;
			default: ovf_evt = 1'b0;
		endcase
		set_vec = 8'h00;
		set_vec[`TCC_BIT_OVF]  = ovf_evt;
		set_vec[`TCC_BIT_CMPA] = match_ff[0];
		set_vec[`TCC_BIT_CMPB] = match_ff[1];
		set_vec[`TCC_BIT_CMPC] = match_ff[2];
		set_vec[`TCC_BIT_CAP]  = cap_is_top ? top_in : cap_evt_in;
	end

	// Capture storage; a bus write wins over a same-cycle event.
	// Flags: a new event wins over a clear in the same cycle.
	always @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			cap_ff   <= {WIDTH{1'b0}};
			flags_ff <= `TCC_FLAGS_RESET;
		end
		else
		begin
			if (cap_wr_in)
				cap_ff <= wr_data_in;
			else if (cap_evt_in && !cap_is_top)
				cap_ff <= counter_in;
			flags_ff <= ((flags_ff & ~(flag_clr_in | vec_ack_in)) |
				set_vec) & `TCC_FLAG_USED;
		end
	end

	assign cap_out        = cap_ff;
	assign match_out      = match_ff;
	assign flags_out      = flags_ff;
	assign cap_is_top_out = cap_is_top;
endmodule

// >>> tcc_top.v
/*
 * Compare, capture and interrupt flag logic of two 16-bit timers behind an
 * APB slave, with one shared high-byte latch for atomic 16-bit access.
 * Assumes the counter units and waveform generators sit outside, a single
 * 25 MHz clock, synchronous inputs and a synchronous active-low reset.
 */
`include "tcc_defs.vh"
module tcc_top #(parameter WIDTH = 16)
(
	input  wire             clk_sys_in,
	input  wire             rst_n_in,
	input  wire [7:0]       paddr_in,
	input  wire             psel_in,
	input  wire             penable_in,
	input  wire             pwrite_in,
	input  wire [31:0]      pwdata_in,
	output wire [31:0]      prdata_out,
	output wire             pready_out,
	output wire             pslverr_out,
	input  wire             global_irq_enable_in,
	input  wire [WIDTH-1:0] t1_counter_in,
	input  wire             t1_tick_in,
	input  wire             t1_max_in,
	input  wire             t1_top_in,
	input  wire             t1_bottom_in,
	input  wire             t1_capture_pin_in,
	input  wire             t1_analog_comp_in,
	input  wire [7:0]       t1_vector_ack_in,
	input  wire [WIDTH-1:0] t3_counter_in,
	input  wire             t3_tick_in,
	input  wire             t3_max_in,
	input  wire             t3_top_in,
	input  wire             t3_bottom_in,
	input  wire             t3_capture_pin_in,
	input  wire [7:0]       t3_vector_ack_in,
	output wire [WIDTH-1:0] t1_compare_a_out,
	output wire [WIDTH-1:0] t1_capture_out,
	output wire [2:0]       t1_match_out,
	output wire [2:0]       t1_force_out,
	output wire [7:0]       t1_irq_req_out,
	output wire [WIDTH-1:0] t3_compare_a_out,
	output wire [WIDTH-1:0] t3_capture_out,
	output wire [2:0]       t3_match_out,
	output wire [2:0]       t3_force_out,
	output wire [7:0]       t3_irq_req_out,
	output wire             irq_out
);
	// APB answer state.
	reg  [31:0] prdata_ff;
	reg  [31:0] nxt_prdata;
	reg         pready_ff;
	reg         pslverr_ff;
	reg         nxt_err;
	// Software visible control state.
	reg  [7:0]  t1_mask_ff;
	reg  [7:0]  t3_mask_ff;
	reg  [7:0]  t1_ctrl_ff;
	reg  [7:0]  t3_ctrl_ff;
	reg  [7:0]  temp_ff;
	reg  [2:0]  t1_force_ff;
	reg  [2:0]  t3_force_ff;
	reg  [7:0]  t1_irq_ff;
	reg  [7:0]  t3_irq_ff;
	reg         irq_ff;

	// Decoded strobes toward the two timers.
	reg  [2:0]  t1_cmp_wr;
	reg  [2:0]  t3_cmp_wr;
	reg         t1_cap_wr;
	reg         t3_cap_wr;
	reg  [7:0]  t1_clr;
	reg  [7:0]  t3_clr;
	wire        access;
	wire        wr_go;
	wire        rd_go;
	wire        is_wide;
	wire        wide_t3;
	wire [2:0]  wide_idx;
	wire [WIDTH-1:0] wide_wdata;
	wire [WIDTH*3-1:0] t1_cmp;
	wire [WIDTH*3-1:0] t3_cmp;
	wire [WIDTH-1:0] t1_cap;
	wire [WIDTH-1:0] t3_cap;
	wire [WIDTH*3-1:0] sel_cmp;
	wire [WIDTH-1:0] sel_cap;
	wire [7:0]  t1_flags;
	wire [7:0]  t3_flags;
	wire        t1_cap_top;
	wire        t3_cap_top;
	wire        t1_cap_evt;
	wire        t3_cap_evt;
	wire [7:0]  nxt_t1_irq;
	wire [7:0]  nxt_t3_irq;
	// A transfer completes at the edge where the slave shows pready, so
	// every access phase lasts two cycles: one to prepare, one to answer.
	assign access  = psel_in && penable_in;
	assign wr_go   = access && pready_ff && pwrite_in;
	assign rd_go   = access && pready_ff && !pwrite_in;
	assign is_wide = (paddr_in >= `TCC_OFS_WIDE_BASE) &&
		(paddr_in <= `TCC_OFS_WIDE_LAST);
	assign wide_t3  = paddr_in[`TCC_WIDE_T3_BIT];
	assign wide_idx = paddr_in[4:2];
	assign sel_cmp  = wide_t3 ? t3_cmp : t1_cmp;
	assign sel_cap  = wide_t3 ? t3_cap : t1_cap;
	// The low-byte write carries the latched high byte along.
	assign wide_wdata = {temp_ff, pwdata_in[7:0]};
	// True for modes without PWM, where a forced strobe is allowed.
	function non_pwm;
		input [3:0] mode;
		begin
			non_pwm = (mode == `TCC_MODE_NORMAL) ||
				(mode == `TCC_MODE_CTC_CMPA) ||
				(mode == `TCC_MODE_CTC_CAP);
		end
	endfunction

	// Read data and error for the access under preparation.
	always @*
	begin
		nxt_prdata = 32'h0000_0000;
		nxt_err    = 1'b0;
		if (paddr_in[1:0] != 2'b00)
			nxt_err = 1'b1;
		else if (is_wide)
		begin
			case (wide_idx)
				`TCC_IDX_CAP_LO: nxt_prdata[7:0] = sel_cap[7:0];
				`TCC_IDX_CAP_HI: nxt_prdata[7:0] = temp_ff;
				default: nxt_prdata[7:0] = sel_cmp[wide_idx*8 +: 8];
			endcase
		end
		else
		begin
			case (paddr_in)
				`TCC_OFS_T1_MASK:  nxt_prdata[7:0] = t1_mask_ff;
				`TCC_OFS_T3_MASK:  nxt_prdata[7:0] = t3_mask_ff;
				`TCC_OFS_T1_FLAGS: nxt_prdata[7:0] = t1_flags;
				`TCC_OFS_T3_FLAGS: nxt_prdata[7:0] = t3_flags;
				`TCC_OFS_T1_CTRL:  nxt_prdata[7:0] = t1_ctrl_ff;
				`TCC_OFS_T3_CTRL:  nxt_prdata[7:0] = t3_ctrl_ff;
				`TCC_OFS_T1_FORCE: nxt_prdata = 32'h0000_0000;
				`TCC_OFS_T3_FORCE: nxt_prdata = 32'h0000_0000;
				default:           nxt_err = 1'b1;
			endcase
		end
	end

	// Write decode into per-timer strobes; only low-byte writes reach the
	// 16-bit values, high-byte writes only load the shared latch.
	always @*
	begin
		t1_cmp_wr = 3'b000;
		t3_cmp_wr = 3'b000;
		t1_cap_wr = 1'b0;
		t3_cap_wr = 1'b0;
		t1_clr    = 8'h00;
		t3_clr    = 8'h00;
		if (wr_go && !nxt_err)
		begin
			if (is_wide && !wide_idx[0])
			begin
				if (wide_idx == `TCC_IDX_CAP_LO)
				begin
					t1_cap_wr = !wide_t3;
					t3_cap_wr = wide_t3;
				end
				else
				begin
					t1_cmp_wr[wide_idx[2:1]] = !wide_t3;
					t3_cmp_wr[wide_idx[2:1]] = wide_t3;
				end
			end
			if (paddr_in == `TCC_OFS_T1_FLAGS)
				t1_clr = pwdata_in[7:0] & `TCC_FLAG_USED;
			if (paddr_in == `TCC_OFS_T3_FLAGS)
				t3_clr = pwdata_in[7:0] & `TCC_FLAG_USED;
		end
	end

	// APB answer: one wait state, then pready with data and error.
	always @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= access && !pready_ff;
			prdata_ff  <= (access && !pready_ff && !pwrite_in) ?
				nxt_prdata : 32'h0000_0000;
			pslverr_ff <= access && !pready_ff && nxt_err;
		end
	end

	// Control registers, shared latch and forced strobes. The latch is
	// shared by both timers, so an interrupt handler that touches a 16-bit
	// value between the two byte accesses of the main code corrupts it.
	always @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			t1_mask_ff  <= `TCC_MASK_RESET;
			t3_mask_ff  <= `TCC_MASK_RESET;
			t1_ctrl_ff  <= `TCC_CTRL_RESET;
			t3_ctrl_ff  <= `TCC_CTRL_RESET;
			temp_ff     <= 8'h00;
			t1_force_ff <= 3'b000;
			t3_force_ff <= 3'b000;
		end
		else
		begin
			t1_force_ff <= 3'b000;
			t3_force_ff <= 3'b000;
			if (wr_go && !nxt_err)
			begin
				case (paddr_in)
					`TCC_OFS_T1_MASK:
						t1_mask_ff <= pwdata_in[7:0] & `TCC_FLAG_USED;
					`TCC_OFS_T3_MASK:
						t3_mask_ff <= pwdata_in[7:0] & `TCC_FLAG_USED;
					`TCC_OFS_T1_CTRL:
						t1_ctrl_ff <= pwdata_in[7:0] & `TCC_CTRL_USED;
					`TCC_OFS_T3_CTRL:
						t3_ctrl_ff <= pwdata_in[7:0] & `TCC_CTRL_USED;
					`TCC_OFS_T1_FORCE:
						if (non_pwm(t1_ctrl_ff[3:0]))
							t1_force_ff <= pwdata_in[2:0];
					`TCC_OFS_T3_FORCE:
						if (non_pwm(t3_ctrl_ff[3:0]))
							t3_force_ff <= pwdata_in[2:0];
					default: ;
				endcase
				if (is_wide && wide_idx[0])
					temp_ff <= pwdata_in[7:0];
			end
			else if (rd_go && is_wide && wide_idx == `TCC_IDX_CAP_LO)
				temp_ff <= wide_t3 ? t3_cap[15:8] : t1_cap[15:8];
		end
	end

	// Capture event sources; the comparator choice exists on timer one.
	tcc_edge u_t1_edge
	(
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (t1_capture_pin_in),
		.comp_in     (t1_analog_comp_in),
		.use_comp_in (t1_ctrl_ff[`TCC_CTRL_USE_COMP]),
		.rising_in   (t1_ctrl_ff[`TCC_CTRL_RISING]),
		.enable_in   (!t1_cap_top),
		.evt_out     (t1_cap_evt)
	);
	tcc_edge u_t3_edge
	(
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (t3_capture_pin_in),
		.comp_in     (1'b0),
		.use_comp_in (1'b0),
		.rising_in   (t3_ctrl_ff[`TCC_CTRL_RISING]),
		.enable_in   (!t3_cap_top),
		.evt_out     (t3_cap_evt)
	);

	// The two timers.
	tcc_chan #(.WIDTH(WIDTH)) u_t1
	(
		.clk_sys_in     (clk_sys_in),
		.rst_n_in       (rst_n_in),
		.cmp_wr_in      (t1_cmp_wr),
		.cap_wr_in      (t1_cap_wr),
		.wr_data_in     (wide_wdata),
		.flag_clr_in    (t1_clr),
		.vec_ack_in     (t1_vector_ack_in),
		.mode_in        (t1_ctrl_ff[3:0]),
		.counter_in     (t1_counter_in),
		.tick_in        (t1_tick_in),
		.max_in         (t1_max_in),
		.top_in         (t1_top_in),
		.bottom_in      (t1_bottom_in),
		.cap_evt_in     (t1_cap_evt),
		.cmp_out        (t1_cmp),
		.cap_out        (t1_cap),
		.match_out      (t1_match_out),
		.flags_out      (t1_flags),
		.cap_is_top_out (t1_cap_top)
	);
	tcc_chan #(.WIDTH(WIDTH)) u_t3
	(
		.clk_sys_in     (clk_sys_in),
		.rst_n_in       (rst_n_in),
		.cmp_wr_in      (t3_cmp_wr),
		.cap_wr_in      (t3_cap_wr),
		.wr_data_in     (wide_wdata),
		.flag_clr_in    (t3_clr),
		.vec_ack_in     (t3_vector_ack_in),
		.mode_in        (t3_ctrl_ff[3:0]),
		.counter_in     (t3_counter_in),
		.tick_in        (t3_tick_in),
		.max_in         (t3_max_in),
		.top_in         (t3_top_in),
		.bottom_in      (t3_bottom_in),
		.cap_evt_in     (t3_cap_evt),
		.cmp_out        (t3_cmp),
		.cap_out        (t3_cap),
		.match_out      (t3_match_out),
		.flags_out      (t3_flags),
		.cap_is_top_out (t3_cap_top)
	);

	// Requests are registered so the outputs come from flip-flops; the
	// price is one cycle of latency after a flag or mask changes.
	assign nxt_t1_irq = t1_mask_ff & t1_flags &
		{8{global_irq_enable_in}};
	assign nxt_t3_irq = t3_mask_ff & t3_flags &
		{8{global_irq_enable_in}};

	always @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			t1_irq_ff <= 8'h00;
			t3_irq_ff <= 8'h00;
			irq_ff    <= 1'b0;
		end
		else
		begin
			t1_irq_ff <= nxt_t1_irq;
			t3_irq_ff <= nxt_t3_irq;
			irq_ff    <= |{nxt_t1_irq, nxt_t3_irq};
		end
	end

	// Output wiring, all from flip-flops.
	assign prdata_out       = prdata_ff;
	assign pready_out       = pready_ff;
	assign pslverr_out      = pslverr_ff;
	assign t1_compare_a_out = t1_cmp[WIDTH-1:0];
	assign t3_compare_a_out = t3_cmp[WIDTH-1:0];
	assign t1_capture_out   = t1_cap;
	assign t3_capture_out   = t3_cap;
	assign t1_force_out     = t1_force_ff;
	assign t3_force_out     = t3_force_ff;
	assign t1_irq_req_out   = t1_irq_ff;
	assign t3_irq_req_out   = t3_irq_ff;
	assign irq_out          = irq_ff;
endmodule

// >>> tcc_top_props.sv
/*
 * Port-level checker for the dual compare and capture block.
 * Assumes the single clock domain and the synchronous low reset of the top.
 */
`include "tcc_defs.vh"
module tcc_chk #(parameter WIDTH = 16)
(
	input wire logic             clk_sys_in,
	input wire logic             rst_n_in,
	input wire logic [7:0]       paddr_in,
	input wire logic             psel_in,
	input wire logic             penable_in,
	input wire logic             pwrite_in,
	input wire logic [31:0]      pwdata_in,
	input wire logic             pready_out,
	input wire logic             global_irq_enable_in,
	input wire logic [WIDTH-1:0] t1_counter_in,
	input wire logic             t1_tick_in,
	input wire logic [7:0]       t1_vector_ack_in,
	input wire logic [WIDTH-1:0] t1_compare_a_out,
	input wire logic [WIDTH-1:0] t1_capture_out,
	input wire logic [2:0]       t1_match_out,
	input wire logic [7:0]       t1_irq_req_out,
	input wire logic [7:0]       t3_irq_req_out,
	input wire logic             irq_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// Bus phases and the compare hit that later steps hang on.
	sequence s_access;
		psel_in && penable_in && !pready_out;
	endsequence
	sequence s_commit;
		psel_in && penable_in && pready_out && pwrite_in;
	endsequence
	sequence s_hit;
		t1_tick_in && t1_counter_in == t1_compare_a_out;
	endsequence

	a_apb_answer: assert property (s_access |=> pready_out)
		else $error("access phase not answered");
	a_pready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	a_match_set: assert property (s_hit |=> t1_match_out[0])
		else $error("compare hit gave no match");
	a_match_cause: assert property (t1_match_out[0] |->
		$past(t1_tick_in && t1_counter_in == t1_compare_a_out))
		else $error("match without counter hit");
	a_irq_gate: assert property (|(t1_irq_req_out | t3_irq_req_out)
		|-> $past(global_irq_enable_in))
		else $error("request while globally disabled");
	a_req_layout: assert property
		(((t1_irq_req_out | t3_irq_req_out) & 8'hd0) == 8'h00)
		else $error("request on reserved bit");
	a_vec_clear: assert property (t1_vector_ack_in[1] &&
		!t1_match_out[0] |-> ##2 !t1_irq_req_out[1])
		else $error("vector did not clear request");
	a_w1c_clear: assert property (s_commit ##0
		(paddr_in == `TCC_OFS_T1_FLAGS && pwdata_in[1] &&
		!t1_match_out[0]) |-> ##2 !t1_irq_req_out[1])
		else $error("write one did not clear request");
	a_cap_source: assert property (!$stable(t1_capture_out) |->
		t1_capture_out == $past(t1_counter_in) ||
		$past(psel_in && penable_in && pready_out && pwrite_in))
		else $error("capture value from nowhere");
	a_irq_cause: assert property (irq_out ==
		|(t1_irq_req_out | t3_irq_req_out))
		else $error("interrupt line differs from the requests");
endmodule
bind tcc_top tcc_chk #(.WIDTH(WIDTH)) u_tcc_chk (.*);

// >>> tcc_core.sv
/*
 * Core model that executes interrupt vectors for pending requests.
 * Assumes requests in the flag layout and one ack pulse per vector.
 */
module tcc_core
(
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       service_en_in,
	input  wire logic [7:0] t1_req_in,
	input  wire logic [7:0] t3_req_in,
	output wire logic [7:0] t1_ack_out,
	output wire logic [7:0] t3_ack_out
);
	logic [7:0] t1_ack_ff;
	logic [7:0] t3_ack_ff;
	logic [2:0] hold_ff;
	assign t1_ack_out = t1_ack_ff;
	assign t3_ack_out = t3_ack_ff;
	// Lowest pending vector first; the hold-off lets the request fall
	// before the next look, since it lags the flag by a cycle.
	always @(posedge clk_sys_in)
	begin
		t1_ack_ff <= 8'h00;
		t3_ack_ff <= 8'h00;
		if (!rst_n_in || !service_en_in)
			hold_ff <= 3'h0;
		else if (hold_ff != 3'h0)
			hold_ff <= hold_ff - 3'h1;
		else if (t1_req_in != 8'h00)
		begin
			t1_ack_ff <= t1_req_in & (~t1_req_in + 8'h01);
			hold_ff <= 3'h4;
		end
		else if (t3_req_in != 8'h00)
		begin
			t3_ack_ff <= t3_req_in & (~t3_req_in + 8'h01);
			hold_ff <= 3'h4;
		end
	end
endmodule

// >>> tb.sv
/*
 * Self-checking bench for the dual compare and capture block.
 * Assumes the APB slave answers with one wait state and the core model.
 */
`include "tcc_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, gie = 0;
	logic tk = 0, pin = 0, acmp = 0, svc = 0, perr;
	logic [7:0] pa = 0, a1, a3, r1, r3;
	logic [31:0] pwd = 0, prd, r;
	logic [15:0] cnt = 0, ca1, ca3, cp1, cp3;
	logic [2:0] ev = 0, m1, m3, f1, f3;
	logic pready, pslverr, irq;
	int miscompares = 0, n_checks = 0;
	localparam logic [7:0] F1 = `TCC_OFS_T1_FLAGS, F3 = `TCC_OFS_T3_FLAGS;

	// Clock of 40 ns; both timers share the counter stimulus.
	always #20 clk = ~clk;
	tcc_top u_tcc_top (.clk_sys_in(clk), .rst_n_in(rst_n), .paddr_in(pa),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
		.pslverr_out(pslverr), .global_irq_enable_in(gie),
		.t1_counter_in(cnt), .t1_tick_in(tk), .t1_max_in(ev[0]),
		.t1_top_in(ev[1]), .t1_bottom_in(ev[2]),
		.t1_capture_pin_in(pin), .t1_analog_comp_in(acmp),
		.t1_vector_ack_in(a1), .t3_counter_in(cnt), .t3_tick_in(tk),
		.t3_max_in(ev[0]), .t3_top_in(ev[1]), .t3_bottom_in(ev[2]),
		.t3_capture_pin_in(pin), .t3_vector_ack_in(a3),
		.t1_compare_a_out(ca1), .t1_capture_out(cp1), .t1_match_out(m1),
		.t1_force_out(f1), .t1_irq_req_out(r1), .t3_compare_a_out(ca3),
		.t3_capture_out(cp3), .t3_match_out(m3), .t3_force_out(f3),
		.t3_irq_req_out(r3), .irq_out(irq));
	tcc_core u_tcc_core (.clk_sys_in(clk), .rst_n_in(rst_n),
		.service_en_in(svc), .t1_req_in(r1), .t3_req_in(r3),
		.t1_ack_out(a1), .t3_ack_out(a3));

	task automatic results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One APB transfer; a missing answer ends the run.
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n = 0;
		@(posedge clk);
		pa <= a; pwr <= w; pwd <= {24'h0, d}; psel <= 1;
		@(posedge clk);
		pen <= 1;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
		r = prd; perr = pslverr;
		psel <= 0; pen <= 0;
		if (n >= 16)
		begin
			miscompares++;
			results;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		apb(a, 0, 8'h00);
		chk(r, {24'h0, e});
	endtask
	// Counter value, tick and {bottom, top, max} pulse for one cycle.
	task automatic stim(input logic [15:0] c, input logic t, input logic [2:0] p);
		@(posedge clk);
		cnt <= c; tk <= t; ev <= p;
		@(posedge clk);
		tk <= 0; ev <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic setpin(input logic p, input logic c);
		@(posedge clk);
		pin <= p; acmp <= c;
		repeat (4) @(posedge clk);
	endtask

	task automatic s_regs;
		for (int i = 0; i < 4; i++) rdc(4 * i, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			wr(4 * i, 8'hff);
			rdc(4 * i, 8'h2f);
			wr(4 * i, 8'h00);
		end
		wr(F1, 8'hff);
		rdc(F1, 8'h00);
		apb(8'h60, 0, 8'h00);
		chk(r, 32'h0);
		chk(perr, 1'b1);
	endtask
	task automatic s_compare;
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h24 + 8 * i, 8'h12);
			if (i == 0) chk(ca1, 16'h0000);
			wr(8'h20 + 8 * i, 8'h30 + i);
			rdc(8'h24 + 8 * i, 8'h12);
			stim(16'h1230 + i, 1, 0);
			rdc(F1, 8'h02 << i);
			wr(F1, 8'h00);
			rdc(F1, 8'h02 << i);
			wr(F1, 8'h02 << i);
			rdc(F1, 8'h00);
		end
		chk(ca1, 16'h1230);
		wr(8'h44, 8'h56);
		wr(8'h40, 8'h78);
		@(posedge clk);
		chk(ca3, 16'h5678);
		stim(16'h5678, 1, 0);
		rdc(F3, 8'h02);
		wr(F3, 8'h02);
	endtask
	task automatic s_irq;
		int n = 0;
		wr(`TCC_OFS_T1_MASK, 8'h0e);
		gie <= 1;
		wr(`TCC_OFS_T1_FORCE, 8'h07);
		@(posedge clk);
		chk({f3, f1}, 6'h07);
		repeat (3) @(posedge clk);
		rdc(F1, 8'h00);
		chk({irq, m3, m1}, 7'h00);
		gie <= 0;
		stim(16'h1230, 1, 0);
		chk(irq, 1'b0);
		gie <= 1;
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		svc <= 1;
		while (irq !== 1'b0 && n < 20) begin @(posedge clk); n++; end
		chk(irq, 1'b0);
		rdc(F1, 8'h00);
		svc <= 0;
		wr(`TCC_OFS_T1_MASK, 8'h00);
	endtask
	task automatic s_overflow;
		for (int i = 0; i < 2; i++)
		begin
			wr(`TCC_OFS_T1_CTRL, i ? `TCC_MODE_CTC_CMPA : `TCC_MODE_NORMAL);
			stim(0, 0, 3'b100);
			rdc(F1, 8'h00);
			stim(0, 0, 3'b001);
			rdc(F1, 8'h01);
			rdc(F3, 8'h01);
			wr(F1, 8'h01);
			wr(F3, 8'h01);
		end
	endtask
	task automatic s_capture;
		wr(`TCC_OFS_T1_CTRL, 8'h10);
		stim(16'habcd, 0, 0);
		setpin(1, 0);
		chk(cp1, 16'habcd);
		rdc(F1, 8'h20);
		rdc(8'h38, 8'hcd);
		stim(16'h1111, 0, 0);
		setpin(0, 0);
		setpin(1, 0);
		rdc(8'h3c, 8'hab);
		chk(cp3, 16'h1111);
		rdc(8'h58, 8'h11);
		rdc(8'h5c, 8'h11);
		wr(`TCC_OFS_T1_CTRL, 8'h30);
		stim(16'h2222, 0, 0);
		setpin(1, 1);
		chk(cp1, 16'h2222);
		wr(F1, 8'h20);
		wr(F3, 8'h20);
	endtask
	task automatic s_top;
		wr(`TCC_OFS_T1_CTRL, 8'h1c);
		stim(16'h3333, 0, 0);
		setpin(0, 1);
		setpin(1, 1);
		chk(cp1, 16'h2222);
		rdc(F1, 8'h00);
		stim(0, 0, 3'b010);
		rdc(F1, 8'h20);
		wr(8'h3c, 8'h40);
		wr(8'h38, 8'h00);
		@(posedge clk);
		chk(cp1, 16'h4000);
	endtask

	// Reset for six cycles, then the scenarios in turn.
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		s_regs;
		s_compare;
		s_irq;
		s_overflow;
		s_capture;
		s_top;
		results;
	end
endmodule
